// ===== hdl/acs_pkg.sv
`default_nettype none
package acs_pkg;
   // ----------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [3:0] ADR_CTRL = 4'h0;
   localparam logic [3:0] ADR_RESH = 4'h4;
   localparam logic [3:0] ADR_RESL = 4'h8;
   localparam logic [3:0] ADR_STAT = 4'hC;
   localparam logic [3:0] ADR_CLR = 4'h0;
   localparam logic [3:0] ADR_IEN = 4'h4;
   localparam logic [1:0] PG_MAIN = 2'h0;
   localparam logic [1:0] PG_IRQ = 2'h1;
   // ----------------------------------------
   // control fields
   // ----------------------------------------
   localparam int CTL_GO = 1;
   localparam int CTL_ON = 0;
   localparam int CTL_JUST = 7;
   localparam int CTL_CS_LO = 2;
   localparam int STA_DONE = 6;
   localparam int RES_BITS = 10;
   localparam logic [7:0] CTL_RST = 8'h00;
   localparam logic [7:0] CTL_WMASK = 8'h9D;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int ABORT_WAIT_TAD = 2;
   localparam int ACQ_TIME_NS = 20000;
   localparam int CLK_NS = 10;
   localparam int ACQ_CYC = (ACQ_TIME_NS + CLK_NS - 1) / CLK_NS;
   localparam int RC_DIV = 400;
   typedef enum logic [1:0] {ACS_IDLE, ACS_CONV, ACS_WAIT} acs_state_t;
endpackage
`default_nettype wire

// ===== hdl/acs_tad_gen.sv
`default_nettype none
module acs_tad_gen
   import acs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic run,
   input wire logic [2:0] clkSel,
   output logic tadTick
);
   typedef struct packed {
      logic [9:0] cnt;
      logic tick;
   } acs_tad_st_t;
   acs_tad_st_t st_q, st_d;
   logic [9:0] lim;

   // ----------------------------------------
   // divide select decode
   // ----------------------------------------
   always_comb begin
      case (clkSel)
         3'h0: lim = 10'h001;
         3'h4: lim = 10'h003;
         3'h1: lim = 10'h007;
         3'h5: lim = 10'h00F;
         3'h2: lim = 10'h01F;
         3'h6: lim = 10'h03F;
         default: lim = 10'(RC_DIV - 1);
      endcase
   end

   always_comb begin
      st_d = st_q;
      st_d.tick = 1'b0;
      if (!run) begin
         st_d.cnt = 10'h000;
      end else if (st_q.cnt >= lim) begin
         st_d.cnt = 10'h000;
         st_d.tick = 1'b1;
      end else begin
         st_d.cnt = st_q.cnt + 10'h001;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign tadTick = st_q.tick;

   tick_period_a: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      $rose(run) && clkSel == 3'h0 |-> !tadTick ##1 !tadTick ##1 tadTick)
      else $error("fastest bit period is not two clocks");
endmodule // acs_tad_gen
`default_nettype wire

// ===== hdl/acs_sequencer.sv
`default_nettype none
module acs_sequencer
   import acs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [5:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   input wire logic cmpIn,
   output logic sampleOn,
   output logic [9:0] dacCode,
   output logic irq
);
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] resHi;
      logic [7:0] resLo;
      logic [9:0] sar;
      logic [3:0] bitIdx;
      logic [1:0] waitCnt;
      acs_state_t fsm;
      logic cmp;
      logic doneSt;
      logic doneEn;
      logic ack;
      logic err;
      logic [31:0] rdat;
      logic irq;
      logic samp;
   } acs_seq_st_t;
   acs_seq_st_t st_q, st_d;
   logic tadTick;
   logic tadRun;
   logic wrReq, rdReq, goWr;
   logic [1:0] pg;
   logic [3:0] ofs;
   logic [15:0] resWord;
   default clocking chk_cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);

   acs_tad_gen u_tad (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .run(tadRun),
      .clkSel(st_q.ctrl[CTL_CS_LO+2:CTL_CS_LO]),
      .tadTick(tadTick)
   );

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   assign wrReq = wb_cyc_i && wb_stb_i && wb_we_i && !st_q.ack && !st_q.err
      && wb_sel_i[0];
   assign rdReq = wb_cyc_i && wb_stb_i && !st_q.ack && !st_q.err;
   assign pg = wb_adr_i[5:4];
   assign ofs = wb_adr_i[3:0];
   assign goWr = wrReq && pg == PG_MAIN && ofs == ADR_CTRL;
   // bit clock restarts on every state change
   assign tadRun = st_q.fsm != ACS_IDLE && st_d.fsm == st_q.fsm;

   always_comb begin
      st_d = st_q;
      // comparator is same-clock logic, one register stage
      st_d.cmp = cmpIn;
      st_d.ack = 1'b0;
      st_d.err = 1'b0;
      resWord = 16'h0000;
      // ----------------------------------------
      // register writes
      // ----------------------------------------
      if (goWr) begin
         st_d.ctrl = (wb_dat_i[7:0] & CTL_WMASK) | (st_q.ctrl & ~CTL_WMASK);
         if (!wb_dat_i[CTL_GO]) begin
            st_d.ctrl[CTL_GO] = 1'b0;
         end else if (st_q.ctrl[CTL_ON] && st_q.fsm == ACS_IDLE) begin
            st_d.ctrl[CTL_GO] = 1'b1;
            st_d.fsm = ACS_CONV;
            st_d.sar = 10'h200;
            st_d.bitIdx = 4'(RES_BITS - 1);
            st_d.samp = 1'b0;
         end
      end
      if (wrReq && pg == PG_IRQ && ofs == ADR_IEN) begin
         st_d.doneEn = wb_dat_i[STA_DONE];
      end
      // ----------------------------------------
      // conversion sequence
      // ----------------------------------------
      case (st_q.fsm)
         ACS_CONV: begin
            if (!st_d.ctrl[CTL_GO]) begin
               st_d.fsm = ACS_WAIT;
               st_d.waitCnt = 2'h0;
            end else if (tadTick) begin
               if (!st_q.cmp) begin
                  st_d.sar[st_q.bitIdx] = 1'b0;
               end
               if (st_q.bitIdx == 4'h0) begin
                  resWord = {6'h00, st_d.sar};
                  if (!st_q.ctrl[CTL_JUST]) begin
                     resWord = {st_d.sar, 6'h00};
                  end
                  st_d.resHi = resWord[15:8];
                  st_d.resLo = resWord[7:0];
                  st_d.ctrl[CTL_GO] = 1'b0;
                  st_d.doneSt = 1'b1;
                  st_d.fsm = ACS_IDLE;
                  st_d.samp = st_q.ctrl[CTL_ON];
               end else begin
                  st_d.bitIdx = st_q.bitIdx - 4'h1;
                  st_d.sar[st_q.bitIdx - 4'h1] = 1'b1;
               end
            end
         end
         ACS_WAIT: begin
            if (tadTick) begin
               st_d.waitCnt = st_q.waitCnt + 2'h1;
               if (st_q.waitCnt == 2'(ABORT_WAIT_TAD - 1)) begin
                  st_d.fsm = ACS_IDLE;
                  st_d.samp = st_q.ctrl[CTL_ON];
               end
            end
         end
         default: begin
            st_d.samp = st_d.ctrl[CTL_ON] && st_d.fsm == ACS_IDLE;
         end
      endcase
      // ----------------------------------------
      // status clear, set wins
      // ----------------------------------------
      if (wrReq && pg == PG_IRQ && ofs == ADR_CLR && wb_dat_i[STA_DONE]
         && !(st_d.doneSt && !st_q.doneSt)) begin
         st_d.doneSt = 1'b0;
      end
      st_d.irq = st_d.doneSt && st_d.doneEn;
      // ----------------------------------------
      // bus answer
      // ----------------------------------------
      if (rdReq) begin
         st_d.rdat = 32'h0000_0000;
         if (pg == PG_MAIN && ofs == ADR_CTRL) begin
            st_d.rdat[7:0] = st_q.ctrl;
            st_d.ack = 1'b1;
         end else if (pg == PG_MAIN && ofs == ADR_RESH) begin
            st_d.rdat[7:0] = st_q.resHi;
            st_d.ack = 1'b1;
         end else if (pg == PG_MAIN && ofs == ADR_RESL) begin
            st_d.rdat[7:0] = st_q.resLo;
            st_d.ack = 1'b1;
         end else if (pg == PG_MAIN && ofs == ADR_STAT) begin
            st_d.rdat[STA_DONE] = st_q.doneSt;
            st_d.ack = 1'b1;
         end else if (pg == PG_IRQ && ofs == ADR_IEN) begin
            st_d.rdat[STA_DONE] = st_q.doneEn;
            st_d.ack = 1'b1;
         end else if (pg == PG_IRQ && ofs == ADR_CLR && wb_we_i) begin
            st_d.ack = 1'b1;
         end else begin
            st_d.err = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         st_q <= '0;
         st_q.ctrl <= CTL_RST;
         st_q.fsm <= ACS_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   assign wb_dat_o = st_q.rdat;
   assign wb_ack_o = st_q.ack;
   assign wb_err_o = st_q.err;
   assign irq = st_q.irq;
   assign sampleOn = st_q.samp;
   assign dacCode = st_q.sar;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   go_start_a: assert property (
      goWr && wb_dat_i[CTL_GO] && st_q.ctrl[CTL_ON] && st_q.fsm == ACS_IDLE
      |=> st_q.fsm == ACS_CONV && st_q.ctrl[CTL_GO])
      else $error("go write did not start");
   done_set_a: assert property (
      $fell(st_q.ctrl[CTL_GO]) && st_q.fsm == ACS_IDLE |-> st_q.doneSt)
      else $error("finish without done flag");
   irq_level_a: assert property (
      irq == (st_q.doneSt && st_q.doneEn))
      else $error("irq mismatch");
   abort_keep_a: assert property (
      st_q.fsm == ACS_WAIT |=> $stable(st_q.resHi) && $stable(st_q.resLo))
      else $error("abort changed result");
   abort_wait_a: assert property (
      $rose(st_q.fsm == ACS_WAIT) |-> !sampleOn [*2])
      else $error("reacquire too early");
   right_just_a: assert property (
      st_q.ctrl[CTL_JUST] && $fell(st_q.ctrl[CTL_GO]) && st_q.doneSt
      && !$past(st_q.doneSt) |-> st_q.resHi[7:2] == 6'h00)
      else $error("right justify wrong");
   go_busy_a: assert property (
      st_q.ctrl[CTL_GO] == (st_q.fsm == ACS_CONV))
      else $error("go flag differs from busy state");
   bit_step_a: assert property (
      st_q.fsm == ACS_CONV && !tadTick && !goWr |=> $stable(st_q.bitIdx))
      else $error("bit moved without tick");
   ack_drop_a: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held");
   c_done: cover property ($rose(st_q.doneSt));
   c_abort: cover property ($rose(st_q.fsm == ACS_WAIT));
   c_irq: cover property ($rose(irq));
endmodule // acs_sequencer
`default_nettype wire

// ===== testbench/acs_chan_model.sv
`default_nettype none
module acs_chan_model (
   input wire logic ref_clk,
   input wire logic [9:0] vin,
   input wire logic sampleOn,
   input wire logic [9:0] dacCode,
   output logic cmpIn
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] holdQ = 10'h000;
   // ----------------------------------------
   // hold capacitor and comparator
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (sampleOn) begin
         holdQ <= vin;
      end
   end
   // input half a step above its code
   assign cmpIn = holdQ >= dacCode;
endmodule // acs_chan_model
`default_nettype wire

// ===== testbench/tb_top.sv
`default_nettype none
module tb_top
   import acs_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [5:0] ACT = {PG_MAIN, ADR_CTRL};
   localparam logic [5:0] AST = {PG_MAIN, ADR_STAT};
   localparam logic [5:0] AIE = {PG_IRQ, ADR_IEN};
   logic ref_clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [5:0] adr = 6'h00;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic [9:0] vin = 10'h000, dacCode, v;
   logic cmpIn, sampleOn, irq, ack, err, gotErr, ok;
   logic [7:0] ctl, hiE, loE;
   int error_cnt = 0, tests_run = 0, n;
   int tadT[8] = '{2, 4, 8, 16, 32, 64, 400, 400};
   logic [2:0] csT[8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
   int expQ[$];
   acs_sequencer dut_u (.ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
      .cmpIn(cmpIn), .sampleOn(sampleOn), .dacCode(dacCode), .irq(irq));
   acs_chan_model chan_u (.ref_clk(ref_clk), .vin(vin),
      .sampleOn(sampleOn), .dacCode(dacCode), .cmpIn(cmpIn));
   // ----------------------------------------
   // bus and checks
   // ----------------------------------------
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         $display("MISMATCH %s exp %h got %h", nm, e, g);
         error_cnt++;
      end
   endtask
   task automatic bus(logic w, logic [5:0] a, logic [7:0] d);
      int k;
      k = 0;
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 24'h000000, d};
      do begin
         @(posedge ref_clk);
         k++;
      end while (ack !== 1'b1 && err !== 1'b1 && k < 20);
      q = rdat;
      gotErr = err;
      chk("bus answer", 1'b1, k < 20);
      {cyc, stb} <= 2'b00;
      @(posedge ref_clk);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic start(logic [7:0] c);
      ctl = c;
      v = 10'($urandom_range(0, 1023));
      vin <= v;
      expQ.push_back(v);
      bus(1'b1, ACT, ctl);
      repeat (ACQ_CYC + 10) @(posedge ref_clk);
      bus(1'b1, ACT, ctl | 8'h02);
      bus(1'b0, ACT, 8'h00);
      chk("go busy", 1'b1, q[CTL_GO]);
   endtask
   task automatic conv(int i, logic en);
      start({1'($urandom_range(0, 1)), 2'b00, csT[i], 2'b01});
      n = 0;
      q = 32'h0;
      if (en) begin
         while (irq !== 1'b1 && n < 12 * tadT[i] + 40) begin
            @(posedge ref_clk);
            n++;
         end
         ok = n >= 9 * tadT[i] - 6 && n <= 12 * tadT[i] + 12;
         chk("bit periods", 1'b1, ok);
      end else begin
         while (q[STA_DONE] !== 1'b1 && n < 400) begin
            bus(1'b0, AST, 8'h00);
            n++;
         end
      end
      bus(1'b0, ACT, 8'h00);
      chk("go done", {24'h0, ctl}, q);
      bus(1'b0, AST, 8'h00);
      chk("done flag", 32'h40, q);
      chk("irq", en, irq);
      v = 10'(expQ.pop_front());
      if (ctl[CTL_JUST]) {hiE, loE} = {6'h00, v};
      else {hiE, loE} = {v, 6'h00};
      bus(1'b0, {PG_MAIN, ADR_RESH}, 8'h00);
      chk("result high", {24'h0, hiE}, q);
      bus(1'b0, {PG_MAIN, ADR_RESL}, 8'h00);
      chk("result low", {24'h0, loE}, q);
      bus(1'b1, {PG_IRQ, ADR_CLR}, 8'h40);
      bus(1'b0, AST, 8'h00);
      chk("done clear", 32'h0, q);
      chk("irq clear", 1'b0, irq);
   endtask
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial forever #5 ref_clk = ~ref_clk;
   initial begin
      #900000;
      error_cnt++;
      report_and_stop();
   end
   initial begin
      void'($urandom(76641));
      repeat (4) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      chk("irq reset", 1'b0, irq);
      bus(1'b0, ACT, 8'h00);
      chk("ctrl reset", {24'h0, CTL_RST}, q);
      $display("test reset done");
      bus(1'b1, AIE, 8'h40);
      for (int i = 0; i < 8; i++) conv(i, 1'b1); // rc as divider only
      $display("test clock codes done");
      bus(1'b1, AIE, 8'h00);
      conv(0, 1'b0);
      $display("test masked done");
      start(8'h19);
      repeat (192) @(posedge ref_clk);
      bus(1'b1, ACT, ctl);
      chk("abort sample", 1'b0, sampleOn);
      n = 0;
      while (sampleOn !== 1'b1 && n < 300) begin
         @(posedge ref_clk);
         n++;
      end
      ok = n >= ABORT_WAIT_TAD * tadT[5];
      ok = ok && n <= ABORT_WAIT_TAD * tadT[5] + 4;
      chk("abort wait", 1'b1, ok);
      bus(1'b0, ACT, 8'h00);
      chk("abort go", {24'h0, ctl}, q);
      bus(1'b0, AST, 8'h00);
      chk("abort done", 32'h0, q);
      bus(1'b0, {PG_MAIN, ADR_RESH}, 8'h00);
      chk("kept high", {24'h0, hiE}, q);
      bus(1'b0, {PG_MAIN, ADR_RESL}, 8'h00);
      chk("kept low", {24'h0, loE}, q);
      $display("test abort done");
      bus(1'b1, ACT, 8'h00);
      bus(1'b1, ACT, 8'h03);
      bus(1'b0, ACT, 8'h00);
      chk("go while off", 32'h1, q);
      bus(1'b0, 6'h20, 8'h00);
      chk("unmapped err", 1'b1, gotErr);
      $display("test refusals done");
      report_and_stop();
   end
endmodule // tb_top
`default_nettype wire
